// ==== hfa_host.sv ====
// Avalon-MM master model standing in for the sequencing control.
`timescale 1ns/1ps
`default_nettype none

module hfa_host (
  // Clock
  input wire logic                            mclk,
  // Avalon-MM master
  output logic     [hfa_pkg::HFA_ADDR_W-1:0] avs_address,
  output logic                               avs_read,
  output logic                               avs_write,
  output logic     [31:0]                    avs_writedata,
  input wire logic [31:0]                    avs_readdata,
  input wire logic                           avs_waitrequest,
  // Bench status
  output logic                               hang
);
  import hfa_pkg::*;

  initial begin
    avs_address   = '0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = '0;
    hang          = 1'b0;
  end

  // Released lines show the inverse of the last value so that a slave
  // latching them outside an access does not see a plausible value.
  task automatic xfer(input logic w, input logic [HFA_ADDR_W-1:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_read      <= !w;
    avs_write     <= w;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      hang <= 1'b1;
    end
    rd = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_address   <= ~a;
    avs_writedata <= ~wd;
  endtask
endmodule

`default_nettype wire

// ==== hfa_pkg.sv ====
// Constants shared by the hexadecimal floating-point arithmetic unit.
package hfa_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] HFA_CTRL_OFS  = 8'h00;
  localparam logic [7:0] HFA_INSTR_OFS = 8'h04;
  localparam logic [7:0] HFA_MEMHI_OFS = 8'h08;
  localparam logic [7:0] HFA_MEMLO_OFS = 8'h0C;
  localparam logic [7:0] HFA_ADDR_OFS  = 8'h10;
  localparam logic [7:0] HFA_FPR_OFS   = 8'h20;
  localparam logic [7:0] HFA_GPR_OFS   = 8'h40;
  localparam int         HFA_ADDR_W    = 8;

  // ----------------------------------------------------------------
  // Control and status bits
  // ----------------------------------------------------------------
  localparam int HFA_START_BIT = 0;
  localparam int HFA_BUSY_BIT  = 0;
  localparam int HFA_SPEC_BIT  = 1;
  localparam int HFA_DONE_BIT  = 2;
  localparam int HFA_DVZ_BIT   = 3;

  // ----------------------------------------------------------------
  // Instruction word fields
  // ----------------------------------------------------------------
  localparam int HFA_OP_LSB    = 24;
  localparam int HFA_UNNORM    = 28;
  localparam int HFA_RXFMT     = 29;
  localparam int HFA_LONG      = 30;
  localparam int HFA_R1_LSB    = 20;
  localparam int HFA_R2_LSB    = 16;
  localparam int HFA_B2_LSB    = 12;
  localparam int HFA_D2_W      = 12;

  localparam logic [3:0] HFA_OP_ADD   = 4'h0;
  localparam logic [3:0] HFA_OP_SUB   = 4'h1;
  localparam logic [3:0] HFA_OP_MUL   = 4'h2;
  localparam logic [3:0] HFA_OP_DIV   = 4'h3;
  localparam logic [3:0] HFA_OP_STORE = 4'h4;

  // ----------------------------------------------------------------
  // Number format
  // ----------------------------------------------------------------
  localparam int         HFA_FRAC_W   = 56;
  localparam int         HFA_SHORT_W  = 24;
  localparam logic [6:0] HFA_BIAS     = 7'h40;
  localparam logic [5:0] HFA_DIV_STEPS = 6'h38;
  localparam logic [31:0] HFA_RST_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    HFA_IDLE, HFA_PRE, HFA_ALIGN, HFA_ADD, HFA_MUL, HFA_DIV,
    HFA_POST, HFA_DONE
  } hfa_state_t;

endpackage

// ==== hfa_unit.sv ====
// Hexadecimal floating-point arithmetic unit with an Avalon-MM slave.
// Summary of operation
// - Characteristic is exponent plus 64, excess-64 coding.
// - Sign bit is 0 for positive fraction, 1 for negative.
// - Four 8-byte floating registers serve all register operands.
// - First operand comes from a register; result overwrites it, except store.
// - Normalize by left hex-digit shifts, characteristic minus one per digit.
// - An all-zero fraction is left unchanged by normalization.
// - Add and subtract run normalized or unnormalized; normalized post-normalize.
// - Unnormalized results keep their leading zero digits.
// - Unnormalized input operands are accepted by every operation.
// - Align by right-shifting the smaller-characteristic fraction a digit per step.
// - Subtract inverts the second operand sign, then adds.
// - Product characteristic is sum of characteristics minus 64.
// - Multiply prenormalizes both operands, post-normalizes only if needed.
// - Quotient characteristic is dividend minus divisor plus 64.
// - Divide prenormalizes both operands, never post-normalizes.
// - Register format second field picks second register; same one allowed.
// - Storage address is index plus base plus displacement; field zero adds zero.
// - Register fields other than 0,2,4,6 raise a specification exception.
// - Misaligned storage operand address raises a specification exception.
// - Store writes the result to the second operand location; the code writes the storage words even in register format.
// - Nothing but the final result location is ever changed.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module hfa_unit (
  // Clock and reset
  input  wire logic                           mclk,
  input  wire logic                           reset_n,
  // Avalon-MM slave
  input  wire logic [hfa_pkg::HFA_ADDR_W-1:0] avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  output logic      [31:0]                    avs_readdata,
  output logic                                avs_waitrequest,
  // Status
  output logic                                busy,
  output logic                                spec_exception
);
  import hfa_pkg::*;

  // ----------------------------------------------------------------
  // Storage and working registers
  // ----------------------------------------------------------------
  logic [63:0]      fpr [4];
  logic [31:0]      gpr [16];
  logic [31:0]      instr;
  logic [31:0]      mem_hi;
  logic [31:0]      mem_lo;
  logic             done;
  logic             div_zero;
  logic             ack;
  hfa_state_t       state;
  logic             sa;
  logic             sb;
  logic [6:0]       ca;
  logic [6:0]       cb;
  logic [HFA_FRAC_W-1:0] fa;
  logic [HFA_FRAC_W-1:0] fb;
  logic [HFA_FRAC_W:0]   rem;
  logic [5:0]       cnt;
  logic [31:0]      next_readdata;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  logic [3:0]  opc;
  logic [3:0]  first_operand_reg_field;
  logic [3:0]  second_operand_reg_field;
  logic [3:0]  index_reg_field;
  logic [3:0]  base_reg_field;
  logic [11:0] displacement_field;
  logic        reg_reg_format;
  logic        is_long;
  logic        unnorm;
  logic [23:0] operand_addr;
  logic [31:0] idx_val;
  logic [31:0] base_val;
  logic        bad_reg;
  logic        bad_align;

  assign opc                      = instr[HFA_OP_LSB+:4];
  assign first_operand_reg_field  = instr[HFA_R1_LSB+:4];
  assign second_operand_reg_field = instr[HFA_R2_LSB+:4];
  assign index_reg_field          = instr[HFA_R2_LSB+:4];
  assign base_reg_field           = instr[HFA_B2_LSB+:4];
  assign displacement_field       = instr[HFA_D2_W-1:0];
  assign reg_reg_format           = ~instr[HFA_RXFMT];
  assign is_long                  = instr[HFA_LONG];
  assign unnorm                   = instr[HFA_UNNORM];
  // A zero index or base field stands for no component at all.
  assign idx_val  = (index_reg_field == 4'h0) ? 32'h0
                    : gpr[index_reg_field];
  assign base_val = (base_reg_field == 4'h0) ? 32'h0
                    : gpr[base_reg_field];
  assign operand_addr = 24'(idx_val + base_val
                        + {20'h0, displacement_field});
  // Only even register numbers 0 to 6 name a floating register.
  assign bad_reg = first_operand_reg_field[3]
                 | first_operand_reg_field[0]
                 | (reg_reg_format & (second_operand_reg_field[3]
                 | second_operand_reg_field[0]));
  assign bad_align = ~reg_reg_format & ((operand_addr[1:0] != 2'h0)
                   | (is_long & operand_addr[2]));
  logic [1:0] r1i;
  logic [1:0] r2i;
  assign r1i = first_operand_reg_field[2:1];
  assign r2i = second_operand_reg_field[2:1];
  // Second operand word, from a register or from the storage words.
  logic [63:0] op2;
  assign op2 = reg_reg_format ? fpr[r2i]
             : {mem_hi, is_long ? mem_lo : 32'h0};

  // ----------------------------------------------------------------
  // Avalon-MM handshake
  // ----------------------------------------------------------------
  logic req;
  logic wr_take;
  logic start;
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign wr_take         = avs_write & ack;
  assign start = wr_take & (avs_address == HFA_CTRL_OFS)
               & avs_writedata[HFA_START_BIT] & (state == HFA_IDLE);

  // Every access is answered one cycle after it first appears.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end
  always_comb begin
    next_readdata = 32'h0;
    if (avs_address == HFA_CTRL_OFS) begin
      next_readdata[HFA_BUSY_BIT] = busy;
      next_readdata[HFA_SPEC_BIT] = spec_exception;
      next_readdata[HFA_DONE_BIT] = done;
      next_readdata[HFA_DVZ_BIT]  = div_zero;
    end else if (avs_address == HFA_INSTR_OFS) begin
      next_readdata = instr;
    end else if (avs_address == HFA_MEMHI_OFS) begin
      next_readdata = mem_hi;
    end else if (avs_address == HFA_MEMLO_OFS) begin
      next_readdata = mem_lo;
    end else if (avs_address == HFA_ADDR_OFS) begin
      next_readdata = {8'h0, operand_addr};
    end else if (avs_address[7:5] == HFA_FPR_OFS[7:5]) begin
      next_readdata = avs_address[2] ? fpr[avs_address[4:3]][31:0]
                    : fpr[avs_address[4:3]][63:32];
    end else if (avs_address[7:6] == HFA_GPR_OFS[7:6]) begin
      next_readdata = gpr[avs_address[5:2]];
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= HFA_RST_WORD;
    end else if (avs_read & ~ack) begin
      avs_readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // Software-loaded registers
  // ----------------------------------------------------------------
  // Writes are dropped while an operation runs so that operands and
  // address components stay fixed for its whole length.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      instr <= HFA_RST_WORD;
    end else if (wr_take & ~busy & (avs_address == HFA_INSTR_OFS)) begin
      instr <= avs_writedata;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) begin
        gpr[i] <= HFA_RST_WORD;
      end
    end else if (wr_take & ~busy
                 & (avs_address[7:6] == HFA_GPR_OFS[7:6])) begin
      gpr[avs_address[5:2]] <= avs_writedata;
    end
  end
  // Storage words: the store result lands here, never in a register.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_hi <= HFA_RST_WORD;
      mem_lo <= HFA_RST_WORD;
    end else if (state == HFA_DONE && opc == HFA_OP_STORE) begin
      mem_hi <= fpr[r1i][63:32];
      if (is_long) begin
        mem_lo <= fpr[r1i][31:0];
      end
    end else if (wr_take & ~busy) begin
      if (avs_address == HFA_MEMHI_OFS) begin
        mem_hi <= avs_writedata;
      end
      if (avs_address == HFA_MEMLO_OFS) begin
        mem_lo <= avs_writedata;
      end
    end
  end
  // Floating registers: sign, characteristic, fraction from the top.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        fpr[i] <= 64'h0;
      end
    end else if (state == HFA_DONE && opc != HFA_OP_STORE) begin
      fpr[r1i][63:32] <= {sa, ca, fa[55:32]};
      if (is_long) begin
        fpr[r1i][31:0] <= fa[31:0];
      end
    end else if (wr_take & ~busy
                 & (avs_address[7:5] == HFA_FPR_OFS[7:5])) begin
      if (avs_address[2]) begin
        fpr[avs_address[4:3]][31:0] <= avs_writedata;
      end else begin
        fpr[avs_address[4:3]][63:32] <= avs_writedata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // A new exception in the cycle of a clear wins over the clear.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      spec_exception <= 1'b0;
      done           <= 1'b0;
      div_zero       <= 1'b0;
    end else begin
      if (start & (bad_reg | bad_align)) begin
        spec_exception <= 1'b1;
      end else if (wr_take & (avs_address == HFA_CTRL_OFS)
                   & avs_writedata[HFA_SPEC_BIT]) begin
        spec_exception <= 1'b0;
      end
      if (state == HFA_DIV && cnt == HFA_DIV_STEPS && fb == '0) begin
        div_zero <= 1'b1;
      end else if (start) begin
        div_zero <= 1'b0;
      end
      if (state == HFA_DONE || (start & (bad_reg | bad_align))) begin
        done <= 1'b1;
      end else if (start) begin
        done <= 1'b0;
      end
    end
  end
  assign busy = (state != HFA_IDLE);

  // ----------------------------------------------------------------
  // Arithmetic sequencer
  // ----------------------------------------------------------------
  logic a_lead0;
  logic b_lead0;
  logic [59:0]  sum;
  logic [111:0] prod;
  logic [HFA_FRAC_W+1:0] dtrial;
  assign a_lead0 = (fa != '0) & (fa[55:52] == 4'h0);
  assign b_lead0 = (fb != '0) & (fb[55:52] == 4'h0);
  assign sum     = {4'h0, fa} + {4'h0, fb};
  assign prod    = fa * fb;
  assign dtrial  = {rem, 1'b0} - {2'b00, fb};
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= HFA_IDLE;
      sa    <= 1'b0;
      sb    <= 1'b0;
      ca    <= 7'h0;
      cb    <= 7'h0;
      fa    <= '0;
      fb    <= '0;
      rem   <= '0;
      cnt   <= 6'h0;
    end else begin
      unique case (state)
        HFA_IDLE: begin
          if (start & ~bad_reg & ~bad_align) begin
            sa <= fpr[r1i][63];
            ca <= fpr[r1i][62:56];
            fa <= {fpr[r1i][55:32],
                   is_long ? fpr[r1i][31:0] : 32'h0};
            // Subtract is an add with the second sign turned round.
            sb <= op2[63] ^ (opc == HFA_OP_SUB);
            cb <= op2[62:56];
            fb <= {op2[55:32], is_long ? op2[31:0] : 32'h0};
            if (opc == HFA_OP_ADD || opc == HFA_OP_SUB) begin
              state <= HFA_ALIGN;
            end else if (opc == HFA_OP_MUL || opc == HFA_OP_DIV) begin
              state <= HFA_PRE;
            end else begin
              state <= HFA_DONE;
            end
          end
        end
        HFA_PRE: begin
          if (a_lead0) begin
            fa <= {fa[51:0], 4'h0};
            ca <= 7'(ca - 7'h1);
          end
          if (b_lead0) begin
            fb <= {fb[51:0], 4'h0};
            cb <= 7'(cb - 7'h1);
          end
          if (!a_lead0 && !b_lead0) begin
            if (opc == HFA_OP_MUL) begin
              state <= HFA_MUL;
            end else begin
              // A dividend not below a nonzero divisor is shifted one digit
              // first so that the quotient stays a pure fraction.
              if (fa >= fb && fb != '0) begin
                rem <= {5'h0, fa[55:4]};
                ca  <= 7'(ca + 7'h1 - cb + HFA_BIAS);
              end else begin
                rem <= {1'b0, fa};
                ca  <= 7'(ca - cb + HFA_BIAS);
              end
              sa    <= sa ^ sb;
              fa    <= '0;
              cnt   <= HFA_DIV_STEPS;
              state <= HFA_DIV;
            end
          end
        end
        HFA_ALIGN: begin
          if (ca < cb) begin
            fa <= {4'h0, fa[55:4]};
            ca <= 7'(ca + 7'h1);
          end else if (cb < ca) begin
            fb <= {4'h0, fb[55:4]};
            cb <= 7'(cb + 7'h1);
          end else begin
            state <= HFA_ADD;
          end
        end
        HFA_ADD: begin
          if (sa == sb) begin
            if (sum[56]) begin
              fa <= sum[59:4];
              ca <= 7'(ca + 7'h1);
            end else begin
              fa <= sum[55:0];
            end
            sa <= (sum[56:0] == '0) ? 1'b0 : sa;
          end else if (fa >= fb) begin
            fa <= fa - fb;
            sa <= (fa == fb) ? 1'b0 : sa;
          end else begin
            fa <= fb - fa;
            sa <= sb;
          end
          state <= unnorm ? HFA_DONE : HFA_POST;
        end
        HFA_MUL: begin
          fa <= prod[111:56];
          ca <= 7'(ca + cb - HFA_BIAS);
          sa <= (prod[111:56] == '0) ? 1'b0 : (sa ^ sb);
          state <= HFA_POST;
        end
        HFA_DIV: begin
          // One quotient bit per cycle, restoring division.
          if (!dtrial[HFA_FRAC_W+1]) begin
            rem <= dtrial[HFA_FRAC_W:0];
            fa  <= {fa[54:0], 1'b1};
          end else begin
            rem <= {rem[HFA_FRAC_W-1:0], 1'b0};
            fa  <= {fa[54:0], 1'b0};
          end
          cnt <= 6'(cnt - 6'h1);
          if (cnt == 6'h1) begin
            state <= HFA_DONE;
          end
        end
        HFA_POST: begin
          if (a_lead0) begin
            fa <= {fa[51:0], 4'h0};
            ca <= 7'(ca - 7'h1);
          end else begin
            state <= HFA_DONE;
          end
        end
        HFA_DONE: begin
          state <= HFA_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== hfa_unit_properties.sv ====
// Concurrent checks on the arithmetic unit's bus and status ports.
`timescale 1ns/1ps
`default_nettype none

module hfa_unit_properties (
  // Clock and reset
  input wire logic                           mclk,
  input wire logic                           reset_n,
  // Avalon-MM slave
  input wire logic [hfa_pkg::HFA_ADDR_W-1:0] avs_address,
  input wire logic                           avs_read,
  input wire logic                           avs_write,
  input wire logic [31:0]                    avs_writedata,
  input wire logic [31:0]                    avs_readdata,
  input wire logic                           avs_waitrequest,
  // Status
  input wire logic                           busy,
  input wire logic                           spec_exception
);
  import hfa_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic req;
  logic ctl_wr;
  logic go;
  logic clr;
  assign req    = avs_read | avs_write;
  assign ctl_wr = avs_write & ~avs_waitrequest
                  & (avs_address == HFA_CTRL_OFS);
  assign go     = ctl_wr & avs_writedata[HFA_START_BIT];
  assign clr    = ctl_wr & avs_writedata[HFA_SPEC_BIT];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("waitrequest low in first cycle of an access");
  chk_wait_answer: assert property (req && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("access not answered after one cycle");
  chk_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high without an access");
  chk_busy_cause: assert property ($rose(busy) |-> $past(go))
    else $error("busy rose without a start write");
  chk_spec_cause: assert property ($rose(spec_exception)
    |-> $past(go) && !busy)
    else $error("exception flag set without a refused start");
  chk_spec_sticky: assert property (spec_exception && !clr
    |=> spec_exception)
    else $error("exception flag dropped without a clear");
  chk_spec_clear: assert property (clr && !avs_writedata[0]
    |=> !spec_exception)
    else $error("exception flag survived a clear");
  // The longest run is an add with a 127-digit alignment and a full
  // post-normalization, about 145 cycles.
  chk_busy_bound: assert property ($rose(busy)
    |-> ##[1:150] !busy)
    else $error("operation ran too long");
  chk_rd_unmapped: assert property (avs_read && !avs_waitrequest
    && avs_address >= 8'h80 |-> avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero data");
endmodule

bind hfa_unit hfa_unit_properties hfa_unit_properties_i (
  .mclk(mclk),
  .reset_n(reset_n),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .busy(busy),
  .spec_exception(spec_exception)
);

`default_nettype wire

// ==== test_hex_float_arith_unit.sv ====
// Self-checking bench for the hexadecimal floating-point unit.
`timescale 1ns/1ps
`default_nettype none

module test_hex_float_arith_unit;
  import hfa_pkg::*;

  logic                  mclk;
  logic                  reset_n;
  logic [HFA_ADDR_W-1:0] avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic [31:0]           avs_writedata;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic                  busy;
  logic                  spec_exception;
  logic                  hang;
  int                    failures;
  int                    cmp_count;

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  hfa_host hfa_host_i (
    .mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hang(hang));

  hfa_unit hfa_unit_i (
    .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .busy(busy),
    .spec_exception(spec_exception));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("%0d comparisons, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge hang) begin
    failures++;
    tally_and_finish();
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    hfa_host_i.xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    hfa_host_i.xfer(1'b0, a, 32'h0, d);
  endtask

  task automatic see(input string what, input logic [7:0] a,
                     input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, d, exp);
  endtask

  function automatic logic [7:0] fa(input int k);
    return HFA_FPR_OFS + 8'(k * 8);
  endfunction

  function automatic logic [31:0] ins(input logic [3:0] op,
      input logic un, input logic rx, input logic lg,
      input logic [3:0] r1, input logic [3:0] r2, input logic [3:0] b,
      input logic [11:0] d);
    return {1'b0, lg, rx, un, op, r1, r2, b, d};
  endfunction

  // Loads the instruction, starts it and polls until the unit is idle.
  task automatic run(input logic [31:0] i, input logic [31:0] ctl);
    logic [31:0] d;
    int n;
    wr(HFA_INSTR_OFS, i);
    wr(HFA_CTRL_OFS, 32'h1);
    d = 32'h1;
    n = 0;
    while (d[HFA_BUSY_BIT] !== 1'b0 && n < 300) begin
      rd(HFA_CTRL_OFS, d);
      n++;
    end
    if (d[HFA_BUSY_BIT] !== 1'b0) begin
      failures++;
      tally_and_finish();
    end
    chk("ctrl", d, ctl);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    see("ctrl", HFA_CTRL_OFS, 32'h0);
    see("fpr6", fa(3), 32'h0);
    see("unmapped", 8'hF0, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_add();
    wr(fa(0), 32'h4110_0000);
    wr(fa(0) + 8'h04, 32'h0000_0055);
    wr(fa(1), 32'h4080_0000);
    run(ins(HFA_OP_ADD, 0, 0, 0, 0, 2, 0, 0), 32'h4);
    see("sum", fa(0), 32'h4118_0000);
    see("low word", fa(0) + 8'h04, 32'h0000_0055);
    see("operand", fa(1), 32'h4080_0000);
    wr(fa(1) + 8'h04, 32'h0000_00B7);
    run(ins(HFA_OP_ADD, 0, 0, 1, 0, 2, 0, 0), 32'h4);
    see("long hi", fa(0), 32'h4120_0000);
    see("long lo", fa(0) + 8'h04, 32'h0000_0060);
    wr(fa(3), 32'h4008_0000);
    run(ins(HFA_OP_ADD, 0, 0, 0, 6, 6, 0, 0), 32'h4);
    see("same reg", fa(3), 32'h4010_0000);
    $display("test add done");
  endtask

  task automatic t_sub();
    logic        un [3] = '{1'b1, 1'b0, 1'b0};
    logic [3:0]  r2 [3] = '{4'h6, 4'h6, 4'h4};
    logic [31:0] ex [3] = '{32'hC108_0000, 32'hC080_0000, 32'h4100_0000};
    for (int i = 0; i < 3; i++) begin
      wr(fa(2), 32'h4110_0000);
      wr(fa(3), 32'h4118_0000);
      run(ins(HFA_OP_SUB, un[i], 0, 0, 4, r2[i], 0, 0), 32'h4);
      see("difference", fa(2), ex[i]);
    end
    $display("test subtract done");
  endtask

  task automatic t_muldiv();
    wr(fa(0), 32'h4120_0000);
    wr(fa(1), 32'h4203_0000);
    run(ins(HFA_OP_MUL, 0, 0, 0, 0, 2, 0, 0), 32'h4);
    see("product", fa(0), 32'h4160_0000);
    wr(fa(0), 32'h4203_0000);
    wr(fa(1), 32'h4160_0000);
    run(ins(HFA_OP_DIV, 0, 0, 0, 0, 2, 0, 0), 32'h4);
    see("quotient", fa(0), 32'h4080_0000);
    wr(fa(1), 32'h4000_0000);
    run(ins(HFA_OP_DIV, 0, 0, 0, 0, 2, 0, 0), 32'hC);
    $display("test multiply divide done");
  endtask

  task automatic t_storage();
    wr(HFA_GPR_OFS, 32'h40);
    wr(HFA_GPR_OFS + 8'h04, 32'h100);
    wr(HFA_GPR_OFS + 8'h08, 32'h20);
    wr(HFA_MEMHI_OFS, 32'h4080_0000);
    wr(fa(0), 32'h4110_0000);
    run(ins(HFA_OP_ADD, 0, 1, 0, 0, 1, 2, 12'h008), 32'h4);
    see("address", HFA_ADDR_OFS, 32'h128);
    see("sum", fa(0), 32'h4118_0000);
    see("index", HFA_GPR_OFS + 8'h04, 32'h100);
    see("storage", HFA_MEMHI_OFS, 32'h4080_0000);
    run(ins(HFA_OP_STORE, 0, 1, 1, 0, 0, 2, 12'h010), 32'h4);
    see("address", HFA_ADDR_OFS, 32'h30);
    see("stored", HFA_MEMHI_OFS, 32'h4118_0000);
    see("stored low", HFA_MEMLO_OFS, 32'h0000_0060);
    see("source", fa(0), 32'h4118_0000);
    $display("test storage done");
  endtask

  task automatic t_spec();
    logic [31:0] bad [3];
    logic [31:0] d;
    bad[0] = ins(HFA_OP_ADD, 0, 0, 0, 1, 2, 0, 0);
    bad[1] = ins(HFA_OP_ADD, 0, 0, 0, 0, 3, 0, 0);
    bad[2] = ins(HFA_OP_ADD, 0, 1, 1, 0, 0, 2, 12'h004);
    wr(fa(0), 32'h4110_0000);
    run(ins(4'h5, 0, 0, 0, 0, 2, 0, 0), 32'h4);
    see("no operation", fa(0), 32'h4110_0000);
    for (int i = 0; i < 3; i++) begin
      run(bad[i], 32'h6);
      chk("exception pin", {31'h0, spec_exception}, 32'h1);
      see("kept", fa(0), 32'h4110_0000);
      wr(HFA_CTRL_OFS, 32'h2);
      rd(HFA_CTRL_OFS, d);
      chk("cleared", {31'h0, d[HFA_SPEC_BIT]}, 32'h0);
    end
    $display("test exception done");
  endtask

  initial begin
    failures  = 0;
    cmp_count = 0;
    reset_n   = 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_add();
    t_sub();
    t_muldiv();
    t_storage();
    t_spec();
    tally_and_finish();
  end
endmodule

`default_nettype wire
